// ===== rtl/threshold_irq_regs.svh
// threshold-crossing interrupt enable: register offset, reset value and field positions
// assumes a 6-bit register address and 24-bit register data from the serial decoder
`ifndef THRESHOLD_IRQ_REGS_SVH
`define THRESHOLD_IRQ_REGS_SVH

`define CFG_FOUR_OFFSET        6'h28
`define CFG_FOUR_RESET         24'h000000
`define CFG_FOUR_WIDTH         24

// field positions inside the enable register
`define SW22_SEL_LSB           0
`define SW22_SEL_MSB           5
`define SW23_SEL_LSB           6
`define SW23_SEL_MSB           15
`define SUPPLY_ZERO_SEL_LSB    16
`define SUPPLY_ZERO_SEL_MSB    19
`define SUPPLY_ONE_SEL_LSB     20
`define SUPPLY_ONE_SEL_MSB     23

// one 2-bit edge code per threshold comparison, twelve in all
`define CROSS_CHANNELS         12
`define ADC_CODE_WIDTH         10

// edge code values
`define EDGE_NONE              2'h0
`define EDGE_RISING            2'h1
`define EDGE_FALLING           2'h2
`define EDGE_EITHER            2'h3

`endif

// ===== rtl/threshold_irq_pkg.sv
// types shared by the threshold-crossing interrupt enable block
// assumes threshold_irq_regs.svh is on the include path
`include "threshold_irq_regs.svh"

package threshold_irq_pkg;

    typedef logic [1:0]                     edge_code_type;
    typedef logic [`ADC_CODE_WIDTH-1:0]     adc_code_type;
    typedef logic [`CFG_FOUR_WIDTH-1:0]     cfg_word_type;
    typedef logic [`CROSS_CHANNELS-1:0]     channel_vec_type;

endpackage

// ===== rtl/threshold_crossing_irq_enable.sv
// threshold-crossing interrupt enable register and crossing detector
// assumes register strobes and comparator results come from logic on clk
//
// Overview of operation
// - Register bits 21:20 choose none, rising, falling or both crossings of supply threshold one A.
// - Register bits 23:22 choose the same edge coding for supply threshold one B.
// - Register bits 17:16 choose the edge coding for supply threshold zero A.
// - Register bits 19:18 choose the edge coding for supply threshold zero B.
// - Register bits 7:6 choose the edge coding of switch input 23 against shared threshold three A.
// - Register bits 9:8 choose the edge coding of switch input 23 against shared threshold three B.
// - Register bits 11:10 choose the edge coding of switch input 23 against shared threshold three C.
// - Register bits 13:12 choose the edge coding of switch input 23 against ADC threshold eight.
// - Register bits 15:14 choose the edge coding of switch input 23 against ADC threshold nine.
// - Register bits 1:0, 3:2 and 5:4 choose the edge coding of switch input 22 against thresholds three A, B, C.
// - The enable register sits at offset 28h and resets to zero so that no crossing interrupt is armed.
// - All enable fields are read/write and a read returns the last value written.
// - ADC thresholds eight and nine are 10-bit values that the input 23 code is compared against.
`timescale 1ns/1ps
`include "threshold_irq_regs.svh"

module threshold_crossing_irq_enable
#(
    parameter int CHANNELS = `CROSS_CHANNELS,
    parameter int CODE_W   = `ADC_CODE_WIDTH
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // register access from the serial interface decoder
    input  wire logic                   regWrEn,
    input  wire logic                   regRdEn,
    input  wire logic [5:0]             regAddr,
    input  wire logic [23:0]            regWrData,
    output logic      [23:0]            regRdData_q,
    output logic                        regRdHit_q,
    // sampled comparator results, valid with sampleValid
    input  wire logic                   sampleValid,
    input  wire logic [2:0]             switchTwentytwoAbove,
    input  wire logic [2:0]             switchTwentythreeAbove,
    input  wire logic [3:0]             supplyAbove,
    input  wire logic [CODE_W-1:0]      switchTwentythreeCode,
    input  wire logic [CODE_W-1:0]      adcThresholdEight,
    input  wire logic [CODE_W-1:0]      adcThresholdNine,
    // crossing reports
    output logic [CHANNELS-1:0]         crossingEvent_q,
    output logic [CHANNELS-1:0]         crossingRising_q,
    output logic                        irqRequest_q,
    output logic [23:0]                 enableCfg_q
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // enable register

    threshold_irq_pkg::cfg_word_type    cfgFour_q;
    threshold_irq_pkg::cfg_word_type    cfgFour_d;
    logic                               cfgHit;
    logic                               cfgWrite;
    logic                               cfgRead;

    assign cfgHit   = (regAddr == `CFG_FOUR_OFFSET);
    assign cfgWrite = regWrEn && cfgHit;
    assign cfgRead  = regRdEn && cfgHit;
    assign cfgFour_d = cfgWrite ? regWrData : cfgFour_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfgFour_q <= `CFG_FOUR_RESET;
        end
        else
        begin
            cfgFour_q <= cfgFour_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // read path: unmapped addresses read as zero

    logic [23:0]                        rdData_d;
    logic                               rdHit_d;

    // a write and a read in the same cycle return the old contents
    assign rdData_d = cfgRead ? cfgFour_q : 24'h000000;
    assign rdHit_d  = cfgRead;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            regRdData_q <= 24'h000000;
            regRdHit_q  <= 1'b0;
        end
        else
        begin
            regRdData_q <= rdData_d;
            regRdHit_q  <= rdHit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // field views of the enable register

    logic [5:0]                         switchTwentytwoIrqSel;
    logic [9:0]                         switchTwentythreeIrqSel;
    logic [3:0]                         supplyMonitorZeroIrqSel;
    logic [3:0]                         supplyMonitorOneIrqSel;

    assign switchTwentytwoIrqSel   = cfgFour_q[`SW22_SEL_MSB:`SW22_SEL_LSB];
    assign switchTwentythreeIrqSel = cfgFour_q[`SW23_SEL_MSB:`SW23_SEL_LSB];
    assign supplyMonitorZeroIrqSel = cfgFour_q[`SUPPLY_ZERO_SEL_MSB:`SUPPLY_ZERO_SEL_LSB];
    assign supplyMonitorOneIrqSel  = cfgFour_q[`SUPPLY_ONE_SEL_MSB:`SUPPLY_ONE_SEL_LSB];

    // channel i is governed by register bits [2i+1:2i]
    logic [2*CHANNELS-1:0]              edgeSel;

    assign edgeSel = {supplyMonitorOneIrqSel,       // one B one A
                      supplyMonitorZeroIrqSel,      // zero B zero A
                      switchTwentythreeIrqSel,      // nine, eight, 3C, 3B, 3A
                      switchTwentytwoIrqSel};       // 3C, 3B, 3A

    ////////////////////////////////////////////////////////////////////////////////////////
    // comparison results in register order

    logic                               aboveEight;
    logic                               aboveNine;
    threshold_irq_pkg::channel_vec_type aboveNow;

    assign aboveEight = (switchTwentythreeCode > adcThresholdEight);
    assign aboveNine  = (switchTwentythreeCode > adcThresholdNine);
    assign aboveNow   = {supplyAbove,
                         aboveNine,
                         aboveEight,
                         switchTwentythreeAbove,
                         switchTwentytwoAbove};

    ////////////////////////////////////////////////////////////////////////////////////////
    // sample history: the first sample after reset only primes the history

    // cycles without sampleValid leave the history untouched
    threshold_irq_pkg::channel_vec_type abovePrev_q;
    logic                               primed_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            abovePrev_q <= '0;
            primed_q    <= 1'b0;
        end
        else if (sampleValid)
        begin
            abovePrev_q <= aboveNow;
            primed_q    <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // per-channel edge qualification

    threshold_irq_pkg::channel_vec_type riseHit;
    threshold_irq_pkg::channel_vec_type fallHit;
    threshold_irq_pkg::channel_vec_type eventHit;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : gen_channel
            threshold_irq_pkg::edge_code_type code;
            logic                             changed;

            // code bit 0 arms the rising direction, code bit 1 the falling one
            assign code    = edgeSel[2*ch+1:2*ch];
            // a change is only judged between two valid samples
            assign changed = sampleValid && primed_q && (aboveNow[ch] != abovePrev_q[ch]);
            assign riseHit[ch] = changed && aboveNow[ch]
                                 && ((code == `EDGE_RISING) || (code == `EDGE_EITHER));
            assign fallHit[ch] = changed && !aboveNow[ch]
                                 && ((code == `EDGE_FALLING) || (code == `EDGE_EITHER));
            assign eventHit[ch] = riseHit[ch] || fallHit[ch];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // registered reports

    // reports stand for exactly one cycle after the sample edge
    logic                               irqRequest_d;

    // any armed crossing on any channel raises the request
    assign irqRequest_d = |eventHit;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            crossingEvent_q  <= '0;
            crossingRising_q <= '0;
            irqRequest_q     <= 1'b0;
        end
        else
        begin
            crossingEvent_q  <= eventHit;
            crossingRising_q <= riseHit;
            irqRequest_q     <= irqRequest_d;
        end
    end

    // configuration mirror for the rest of the device
    // it tracks the register itself, so it moves on the write edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            enableCfg_q <= `CFG_FOUR_RESET;
        end
        else
        begin
            enableCfg_q <= cfgFour_d;
        end
    end

endmodule

// ===== testbench/threshold_irq_chk.sv
// checker: register access and crossing report timing of the enable block
// assumes it is bound to threshold_crossing_irq_enable and sees only its ports
`timescale 1ns/1ps
module threshold_irq_chk
#(
    parameter int CHANNELS = 12
)
(
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                regWrEn,
    input wire logic                regRdEn,
    input wire logic [5:0]          regAddr,
    input wire logic [23:0]         regWrData,
    input wire logic [23:0]         regRdData_q,
    input wire logic                regRdHit_q,
    input wire logic                sampleValid,
    input wire logic [CHANNELS-1:0] crossingEvent_q,
    input wire logic [CHANNELS-1:0] crossingRising_q,
    input wire logic                irqRequest_q,
    input wire logic [23:0]         enableCfg_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic [CHANNELS-1:0] riseOk;
    wire logic [CHANNELS-1:0] fallOk;
    wire logic                rdHit = regRdEn && regAddr == 6'h28;
    wire logic                wrHit = regWrEn && regAddr == 6'h28;
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_ok
        assign riseOk[i] = enableCfg_q[2*i];
        assign fallOk[i] = enableCfg_q[2*i+1];
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_read_hit: assert property (rdHit |=> regRdHit_q && regRdData_q == $past(enableCfg_q))
        else $error("read of enable register wrong");
    a_read_miss: assert property (!rdHit |=> !regRdHit_q && regRdData_q == 24'h000000)
        else $error("read answer without hit");
    a_write_take: assert property (wrHit |=> enableCfg_q == $past(regWrData))
        else $error("write not taken");
    a_cfg_hold: assert property (!wrHit |=> $stable(enableCfg_q))
        else $error("enable register changed without write");
    a_irq_or: assert property (irqRequest_q == |crossingEvent_q)
        else $error("interrupt request differs from events");
    a_event_sampled: assert property (|crossingEvent_q |-> $past(sampleValid))
        else $error("event without sample");
    a_rise_allowed: assert property ((crossingEvent_q & crossingRising_q & ~$past(riseOk)) == '0)
        else $error("rising event not enabled");
    a_fall_allowed: assert property ((crossingEvent_q & ~crossingRising_q & ~$past(fallOk)) == '0)
        else $error("falling event not enabled");
endmodule
bind threshold_crossing_irq_enable threshold_irq_chk #(.CHANNELS(CHANNELS)) chk_u
(
    .clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData_q(regRdData_q), .regRdHit_q(regRdHit_q),
    .sampleValid(sampleValid), .crossingEvent_q(crossingEvent_q),
    .crossingRising_q(crossingRising_q), .irqRequest_q(irqRequest_q), .enableCfg_q(enableCfg_q)
);

// ===== testbench/host_model.sv
// host side of register access: one-cycle read or write strobes
// assumes the design samples on the rising edge; strobes move at falling edges
`timescale 1ns/1ps
module host_model
(
    input  wire logic        clk,
    output logic             regWrEn,
    output logic             regRdEn,
    output logic [5:0]       regAddr,
    output logic [23:0]      regWrData,
    input  wire logic [23:0] regRdData_q,
    input  wire logic        regRdHit_q
);
    initial
    begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 6'h00;
        regWrData = 24'h000000;
    end
    // idle address and data are inverted so stale values cannot pass
    task automatic access(input bit wr, input logic [5:0] a, input logic [23:0] d,
                          output logic [23:0] q, output logic hit);
        @(negedge clk);
        regWrEn = wr;
        regRdEn = !wr;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
        q = regRdData_q;
        hit = regRdHit_q;
    endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench: host accesses and random comparator samples against a model
// assumes the design, package, checker and host_model are compiled first
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, regWrEn, regRdEn, regRdHit_q, sampleValid, irq, h;
    logic [5:0]  regAddr, a;
    logic [23:0] regWrData, regRdData_q, cfg, q, d;
    logic [2:0]  sw22, sw23;
    logic [3:0]  supply;
    logic [9:0]  code, thr8, thr9;
    logic [11:0] ev, rise, prevAb, nowAb, expEv, expRise;
    threshold_irq_pkg::cfg_word_type mCfg;
    int          miscompares, cmp_count, seed = 1010;
    bit          primed;
    threshold_crossing_irq_enable dut_u (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q),
        .regRdHit_q(regRdHit_q), .sampleValid(sampleValid), .switchTwentytwoAbove(sw22),
        .switchTwentythreeAbove(sw23), .supplyAbove(supply), .switchTwentythreeCode(code),
        .adcThresholdEight(thr8), .adcThresholdNine(thr9), .crossingEvent_q(ev),
        .crossingRising_q(rise), .irqRequest_q(irq), .enableCfg_q(cfg));
    host_model host_u (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData_q(regRdData_q), .regRdHit_q(regRdHit_q));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task close_out;
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        {mCfg, primed, expEv, expRise} = '0;
    endtask
    // one cycle: check what the last edge produced, then drive a new sample
    task automatic step(input bit v);
        chk(24'(ev), 24'(expEv));
        chk(24'(rise & expEv), 24'(expRise));
        chk(24'(irq), 24'(|expEv));
        chk(cfg, mCfg);
        sampleValid = v;
        {sw22, sw23, supply, code, thr8, thr9} = 40'({$random(seed), $random(seed)});
        nowAb = {supply, code > thr9, code > thr8, sw23, sw22};
        {expEv, expRise} = '0;
        for (int i = 0; v && primed && i < 12; i++)
            if (nowAb[i] != prevAb[i] && mCfg[2*i + (nowAb[i] ? 0 : 1)])
                {expEv[i], expRise[i]} = {1'b1, nowAb[i]};
        if (v)
            {prevAb, primed} = {nowAb, 1'b1};
        @(negedge clk);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        {sampleValid, sw22, sw23, supply, code, thr8, thr9} = '0;
        do_reset();
        for (int r = 0; r < 12; r++)
        begin
            if (r == 7)
                do_reset();
            host_u.access(0, 6'h28, 24'h0, q, h);
            chk(q, mCfg);
            chk(24'(h), 24'h000001);
            d = 24'($random(seed));
            a = r[0] ? 6'h28 : 6'($random(seed) & 6'h1F);
            host_u.access(1, a, d, q, h);
            if (a == 6'h28)
                mCfg = d;
            host_u.access(0, a, 24'h0, q, h);
            chk(q, r[0] ? mCfg : 24'h000000);
            chk(24'(h), r[0] ? 24'h000001 : 24'h000000);
            for (int s = 0; s < 60; s++)
                step($random(seed) % 4 != 0);
            step(0);
        end
        close_out();
    end
endmodule
